// [core/sscr_config_top.v]
// configuration register bank of the synthesizer behind a 3-wire serial port
// assumes: serial pins are asynchronous; outputs feed the synthesizer core
`include "sscr_map.vh"
module sscr_config_top
(
   clk_sys,
   rst_n,
   serial_clk,
   serial_data,
   latch_strobe,
   ramp_enable,
   output_mux_select,
   integer_value,
   fractional_numerator,
   phase_adjust_enable,
   phase_accum,
   phase_update,
   ref_div_config,
   function_config,
   clock_divider_config,
   deviation_config,
   ramp_step_config,
   ramp_delay_config,
   frequency_update
);
   input  wire        clk_sys;
   input  wire        rst_n;
   input  wire        serial_clk;
   input  wire        serial_data;
   input  wire        latch_strobe;
   output reg         ramp_enable;
   output reg  [3:0]  output_mux_select;
   output reg  [11:0] integer_value;
   output reg  [24:0] fractional_numerator;
   output reg         phase_adjust_enable;
   output reg  [11:0] phase_accum;
   output reg         phase_update;
   output reg  [31:0] ref_div_config;
   output reg  [31:0] function_config;
   output reg  [31:0] clock_divider_config;
   output reg  [31:0] deviation_config;
   output reg  [31:0] ramp_step_config;
   output reg  [31:0] ramp_delay_config;
   output reg         frequency_update;

   wire        sclk_lvl;
   wire        sdata_lvl;
   wire        le_lvl;
   wire [31:0] shift_word;
   reg         sclk_d_r;
   reg         le_d_r;
   reg  [31:0] integer_fractional_numerator_msb_r;
   reg  [31:0] fractional_numerator_lsb_phase_r;
   reg  [31:0] ref_div_hold_r;
   wire        shift_pulse;
   wire        latch_pulse;
   wire [2:0]  sel;

   // select code is the three lsbs of the shifted word
   function [2:0] sel_of;
      input [31:0] w;
      begin
         sel_of = w[`SSCR_SEL_MSB:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // pin synchronisers
   sscr_pin_sync u_sync_clk
   (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .pin_in    (serial_clk),
      .level_out (sclk_lvl)
   );
   sscr_pin_sync u_sync_data
   (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .pin_in    (serial_data),
      .level_out (sdata_lvl)
   );
   sscr_pin_sync u_sync_le
   (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .pin_in    (latch_strobe),
      .level_out (le_lvl)
   );

   ////////////////////////////////////////////////////////////////
   // edge detection of filtered levels; delayed copies idle low like the pins
   // delayed serial clock level
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         sclk_d_r <= `SSCR_BIT_RESET;
      else
         sclk_d_r <= sclk_lvl;
   end

   // delayed latch strobe level
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         le_d_r <= `SSCR_BIT_RESET;
      else
         le_d_r <= le_lvl;
   end

   assign shift_pulse = sclk_lvl & ~sclk_d_r;
   assign latch_pulse = le_lvl & ~le_d_r;
   assign sel         = sel_of(shift_word);

   sscr_shift_reg u_shift
   (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .shift_en (shift_pulse),
      .data_bit (sdata_lvl),
      .word_out (shift_word)
   );

   ////////////////////////////////////////////////////////////////
   // load strobe of one holding register: strobe edge with matching code
   function hit;
      input       pulse;
      input [2:0] s;
      input [2:0] code;
      begin
         hit = pulse & (s == code);
      end
   endfunction

   // one load strobe per holding register; nothing loads while shifting
   wire        ld_int_fractional_numerator  = hit(latch_pulse, sel, `SSCR_SEL_INT_FRACTIONAL_NUMERATOR);
   wire        ld_fractional_numerator_lsb  = hit(latch_pulse, sel, `SSCR_SEL_FRACTIONAL_NUMERATOR_LSB);
   wire        ld_ref_div   = hit(latch_pulse, sel, `SSCR_SEL_REF_DIV);
   wire        ld_function  = hit(latch_pulse, sel, `SSCR_SEL_FUNCTION);
   wire        ld_clock     = hit(latch_pulse, sel, `SSCR_SEL_CLOCK);
   wire        ld_deviation = hit(latch_pulse, sel, `SSCR_SEL_DEVIATION);
   wire        ld_step      = hit(latch_pulse, sel, `SSCR_SEL_STEP);
   wire        ld_delay     = hit(latch_pulse, sel, `SSCR_SEL_DELAY);

   ////////////////////////////////////////////////////////////////
   // holding registers: only the selected one moves, only at strobe
   // integer and fractional-msb word
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         integer_fractional_numerator_msb_r <= `SSCR_WORD_RESET;
      else if (ld_int_fractional_numerator)
         integer_fractional_numerator_msb_r <= shift_word;
   end

   // fractional-lsb and phase word, buffered until register zero
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         fractional_numerator_lsb_phase_r <= `SSCR_WORD_RESET;
      else if (ld_fractional_numerator_lsb)
         fractional_numerator_lsb_phase_r <= shift_word;
   end

   // reference divider word, buffered until register zero
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         ref_div_hold_r <= `SSCR_WORD_RESET;
      else if (ld_ref_div)
         ref_div_hold_r <= shift_word;
   end

   // function word, active at once
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         function_config <= `SSCR_WORD_RESET;
      else if (ld_function)
         function_config <= shift_word;
   end

   // clock divider word, active at once
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         clock_divider_config <= `SSCR_WORD_RESET;
      else if (ld_clock)
         clock_divider_config <= shift_word;
   end

   // deviation word, active at once
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         deviation_config <= `SSCR_WORD_RESET;
      else if (ld_deviation)
         deviation_config <= shift_word;
   end

   // ramp step word, active at once
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         ramp_step_config <= `SSCR_WORD_RESET;
      else if (ld_step)
         ramp_step_config <= shift_word;
   end

   // ramp delay word, active at once
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         ramp_delay_config <= `SSCR_WORD_RESET;
      else if (ld_delay)
         ramp_delay_config <= shift_word;
   end

   ////////////////////////////////////////////////////////////////
   // active settings: register zero fields and buffered copies move together
   // one cycle after a register zero latch, read from the holding registers
   // strobes come many cycles apart, so no holding register moves meanwhile
   reg         act_load_r;

   // delayed register zero strobe
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         act_load_r <= `SSCR_BIT_RESET;
      else
         act_load_r <= ld_int_fractional_numerator;
   end

   // ramp enable
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         ramp_enable <= `SSCR_BIT_RESET;
      else if (act_load_r)
         ramp_enable <= integer_fractional_numerator_msb_r[`SSCR_RAMP_ON_BIT];
   end

   // output multiplexer source
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         output_mux_select <= `SSCR_MUX_RESET;
      else if (act_load_r)
         output_mux_select <= integer_fractional_numerator_msb_r[`SSCR_MUX_MSB:`SSCR_MUX_LSB];
   end

   // integer divide value
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         integer_value <= `SSCR_INT_RESET;
      else if (act_load_r)
         integer_value <= integer_fractional_numerator_msb_r[`SSCR_INT_MSB:`SSCR_INT_LSB];
   end

   // fractional numerator: msb part over the buffered lsb part
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         fractional_numerator <= `SSCR_FRACTIONAL_NUMERATOR_RESET;
      else if (act_load_r)
         fractional_numerator <= {integer_fractional_numerator_msb_r[`SSCR_FMSB_MSB:`SSCR_FMSB_LSB],
                                  fractional_numerator_lsb_phase_r[`SSCR_FLSB_MSB:`SSCR_FLSB_LSB]};
   end

   // buffered reference divider word
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         ref_div_config <= `SSCR_WORD_RESET;
      else if (act_load_r)
         ref_div_config <= ref_div_hold_r;
   end

   // phase adjustment enable as applied at the last register zero write
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         phase_adjust_enable <= `SSCR_BIT_RESET;
      else if (act_load_r)
         phase_adjust_enable <= fractional_numerator_lsb_phase_r[`SSCR_PH_EN_BIT];
   end

   // modulo 4096 wrap gives word * 360/4096 degree steps
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         phase_accum <= `SSCR_ACC_RESET;
      else if (act_load_r && fractional_numerator_lsb_phase_r[`SSCR_PH_EN_BIT])
         phase_accum <= phase_accum + fractional_numerator_lsb_phase_r[`SSCR_PH_MSB:`SSCR_PH_LSB];
   end

   // one-cycle pulse when the phase advanced
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         phase_update <= `SSCR_BIT_RESET;
      else
         phase_update <= act_load_r & fractional_numerator_lsb_phase_r[`SSCR_PH_EN_BIT];
   end

   // one-cycle pulse when new frequency settings became active
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         frequency_update <= `SSCR_BIT_RESET;
      else
         frequency_update <= act_load_r;
   end
endmodule // sscr_config_top

// [core/sscr_map.vh]
// constants of the synthesizer serial configuration block
// assumes: included by every design file by bare name
// Overview of operation
// - host shifts 32 bits msb first; one bit taken per serial clock rise
// - latch strobe rise moves word into holding register picked by low three bits
// - double-buffered fields wait for a later write to select code zero
// - select code 000 loads integer and fractional-msb register
// - select code 001 loads fractional-lsb and phase register
// - select code 010 loads reference divider register
// - bit 31 of register zero enables frequency ramp
// - bits 30..27 of register zero pick output multiplexer source
// - bits 26..15 of register zero are 12-bit integer divide value
// - fractional numerator is register one lsb part plus register zero msb part times 2^13
// - register one bit 28 enables phase adjustment; increment applied only then
// - phase word bits 14..3 advances phase after next register zero write
// - phase step equals word times 360 degrees over 4096
`ifndef SSCR_MAP_VH
`define SSCR_MAP_VH
`define SSCR_WORD_W        32
`define SSCR_SEL_MSB       2
`define SSCR_SEL_INT_FRACTIONAL_NUMERATOR  3'h0
`define SSCR_SEL_FRACTIONAL_NUMERATOR_LSB  3'h1
`define SSCR_SEL_REF_DIV   3'h2
`define SSCR_SEL_FUNCTION  3'h3
`define SSCR_SEL_CLOCK     3'h4
`define SSCR_SEL_DEVIATION 3'h5
`define SSCR_SEL_STEP      3'h6
`define SSCR_SEL_DELAY     3'h7
`define SSCR_RAMP_ON_BIT   31
`define SSCR_MUX_MSB       30
`define SSCR_MUX_LSB       27
`define SSCR_INT_MSB       26
`define SSCR_INT_LSB       15
`define SSCR_FMSB_MSB      14
`define SSCR_FMSB_LSB      3
`define SSCR_FLSB_MSB      27
`define SSCR_FLSB_LSB      15
`define SSCR_PH_EN_BIT     28
`define SSCR_PH_MSB        14
`define SSCR_PH_LSB        3
`define SSCR_FLSB_W        13
`define SSCR_PHASE_STEPS   4096
`define SSCR_WORD_RESET    32'h0000_0000
`define SSCR_ACC_RESET     12'h000
`define SSCR_BIT_RESET     1'b0
`define SSCR_MUX_RESET     4'h0
`define SSCR_INT_RESET     12'h000
`define SSCR_FRACTIONAL_NUMERATOR_RESET    25'h000_0000
`endif

// [core/sscr_pin_sync.v]
// three-stage synchroniser with agreement filter for one pin
// assumes: pin is asynchronous to clk_sys
`include "sscr_map.vh"
module sscr_pin_sync
(
   clk_sys,
   rst_n,
   pin_in,
   level_out
);
   input  wire clk_sys;
   input  wire rst_n;
   input  wire pin_in;
   output reg  level_out;

   reg s1_r;
   reg s2_r;
   reg s3_r;

   ////////////////////////////////////////////////////////////////
   // level changes once stages two and three agree
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         s1_r      <= 1'b0;
         s2_r      <= 1'b0;
         s3_r      <= 1'b0;
         level_out <= 1'b0;
      end
      else
      begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
            level_out <= s3_r;
      end
   end
endmodule // sscr_pin_sync

// [core/sscr_shift_reg.v]
// 32-bit input shift register, msb first
// assumes: shift_en is a one-cycle pulse per serial clock rise
`include "sscr_map.vh"
module sscr_shift_reg
(
   clk_sys,
   rst_n,
   shift_en,
   data_bit,
   word_out
);
   input  wire                    clk_sys;
   input  wire                    rst_n;
   input  wire                    shift_en;
   input  wire                    data_bit;
   output reg  [`SSCR_WORD_W-1:0] word_out;

   ////////////////////////////////////////////////////////////////
   // new bit enters at lsb so first bit ends at msb
   always @(posedge clk_sys)
   begin
      if (!rst_n)
         word_out <= `SSCR_WORD_RESET;
      else if (shift_en)
         word_out <= {word_out[`SSCR_WORD_W-2:0], data_bit};
   end
endmodule // sscr_shift_reg

// [test/sscr_config_top_assertions.sv]
// checker on the ports of the serial configuration bank
// assumes: host holds the strobe pin high ten cycles per word
module sscr_chk
(
   input wire        clk_sys,
   input wire        rst_n,
   input wire        latch_strobe,
   input wire        ramp_enable,
   input wire [3:0]  output_mux_select,
   input wire [11:0] integer_value,
   input wire [24:0] fractional_numerator,
   input wire        phase_adjust_enable,
   input wire [11:0] phase_accum,
   input wire        phase_update,
   input wire [31:0] ref_div_config,
   input wire [31:0] function_config,
   input wire [31:0] deviation_config,
   input wire [31:0] ramp_delay_config,
   input wire        frequency_update
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // pulses last one cycle
   a_update_pulse: assert property (frequency_update |=> !frequency_update)
      else $error("update pulse too long");
   a_phase_pulse: assert property (phase_update |=> !phase_update)
      else $error("phase pulse too long");
   // active settings move only with a select zero write
   a_active_hold: assert property (!frequency_update |->
      $stable({ramp_enable, output_mux_select, integer_value, fractional_numerator, ref_div_config}))
      else $error("active setting moved");
   a_enable_hold: assert property (!frequency_update |-> $stable(phase_adjust_enable))
      else $error("phase enable moved");
   a_direct_hold: assert property (!latch_strobe |->
      $stable({function_config, deviation_config, ramp_delay_config}))
      else $error("register moved while shifting");
   a_update_cause: assert property (frequency_update |-> latch_strobe)
      else $error("update without strobe");
   a_phase_cause: assert property (phase_update |-> frequency_update && phase_adjust_enable)
      else $error("phase advanced without cause");
   a_phase_hold: assert property (!phase_update |-> $stable(phase_accum))
      else $error("phase moved without pulse");
   c_phase: cover property (phase_update);
   c_plain: cover property (frequency_update && !phase_update);
   c_direct: cover property ($changed(ramp_delay_config));
endmodule // sscr_chk

bind sscr_config_top sscr_chk chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .latch_strobe(latch_strobe),
   .ramp_enable(ramp_enable), .output_mux_select(output_mux_select), .integer_value(integer_value),
   .fractional_numerator(fractional_numerator), .phase_adjust_enable(phase_adjust_enable),
   .phase_accum(phase_accum), .phase_update(phase_update), .ref_div_config(ref_div_config),
   .function_config(function_config), .deviation_config(deviation_config),
   .ramp_delay_config(ramp_delay_config), .frequency_update(frequency_update));

// [test/sscr_host_model.sv]
// host driving the three serial programming pins
// assumes: bench clock; pins are sampled asynchronously
module sscr_host_model
(
   input  wire  clk_sys,
   output logic serial_clk,
   output logic serial_data,
   output logic latch_strobe
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      latch_strobe = 1'b0;
   end
   // msb first at 800 ns per bit, then the strobe
   task automatic send_word(input logic [31:0] w);
      for (int i = 31; i >= 0; i--)
      begin
         serial_data <= w[i];
         repeat (4) @(negedge clk_sys);
         serial_clk <= 1'b1;
         repeat (4) @(negedge clk_sys);
         serial_clk <= 1'b0;
      end
      serial_data <= ~w[0]; // last bit inverted, no clock edge
      repeat (4) @(negedge clk_sys);
      latch_strobe <= 1'b1;
      repeat (10) @(negedge clk_sys);
      latch_strobe <= 1'b0;
      repeat (4) @(negedge clk_sys);
   endtask
endmodule // sscr_host_model

// [test/sscr_config_top_tb.sv]
// bench for the serial configuration bank
// assumes: design under core/, host model drives the pins
module sscr_config_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [31:0] n_fail = 0;
   logic [31:0] tests_run = 0;
   logic [31:0] n_upd = 0;
   logic [31:0] n_phs = 0;
   wire         serial_clk, serial_data, latch_strobe, ramp_enable, phase_adjust_enable;
   wire         phase_update, frequency_update;
   wire [3:0]   output_mux_select;
   wire [11:0]  integer_value, phase_accum;
   wire [24:0]  fractional_numerator;
   wire [31:0]  ref_div_config, function_config, clock_divider_config;
   wire [31:0]  deviation_config, ramp_step_config, ramp_delay_config;
   always #50 clk_sys = ~clk_sys;
   // count select zero updates and phase advances
   always @(posedge clk_sys)
   begin
      if (frequency_update === 1'b1)
         n_upd <= n_upd + 1;
      if (phase_update === 1'b1)
         n_phs <= n_phs + 1;
   end
   sscr_host_model host (.clk_sys(clk_sys), .serial_clk(serial_clk), .serial_data(serial_data),
      .latch_strobe(latch_strobe));
   sscr_config_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .serial_clk(serial_clk),
      .serial_data(serial_data), .latch_strobe(latch_strobe), .ramp_enable(ramp_enable),
      .output_mux_select(output_mux_select), .integer_value(integer_value),
      .fractional_numerator(fractional_numerator), .phase_adjust_enable(phase_adjust_enable),
      .phase_accum(phase_accum), .phase_update(phase_update), .ref_div_config(ref_div_config),
      .function_config(function_config), .clock_divider_config(clock_divider_config),
      .deviation_config(deviation_config), .ramp_step_config(ramp_step_config),
      .ramp_delay_config(ramp_delay_config), .frequency_update(frequency_update));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run != 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // phase word write with zero reserved bits
   function automatic logic [31:0] r1(input logic en, input logic [12:0] lsb, input logic [11:0] ph);
      return {3'b000, en, lsb, ph, 3'b001};
   endfunction
   function automatic logic [31:0] direct_out(input int s);
      case (s)
         3: return function_config;
         4: return clock_divider_config;
         5: return deviation_config;
         6: return ramp_step_config;
         default: return ramp_delay_config;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(negedge clk_sys);
      n_fail++;
      print_verdict();
   end
   initial
   begin
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      host.send_word(r1(1'b1, 13'h1abc, 12'h0200));
      host.send_word(32'h1234_5672);
      chk("fractional_numerator", 32'(fractional_numerator), 32'h0);
      chk("phase", 32'(phase_accum), 32'h0);
      chk("refdiv", ref_div_config, 32'h0);
      host.send_word({1'b1, 4'ha, 12'h0123, 12'h0456, 3'b000});
      chk("updates", n_upd, 32'h1);
      chk("ramp", 32'(ramp_enable), 32'h1);
      chk("mux", 32'(output_mux_select), 32'ha);
      chk("int", 32'(integer_value), 32'h0123);
      chk("fractional_numerator", 32'(fractional_numerator), 32'({12'h0456, 13'h1abc}));
      chk("phase", 32'(phase_accum), 32'h0200);
      chk("phen", 32'(phase_adjust_enable), 32'h1);
      chk("refdiv", ref_div_config, 32'h1234_5672);
      chk("phase pulses", n_phs, 32'h1);
      $display("test buffered update done");
      host.send_word({1'b0, 4'h5, 12'h00ff, 12'h0456, 3'b000});
      chk("phase", 32'(phase_accum), 32'h0400);
      chk("ramp", 32'(ramp_enable), 32'h0);
      chk("phase pulses", n_phs, 32'h2);
      host.send_word(r1(1'b0, 13'h0001, 12'h0064));
      host.send_word({1'b0, 4'h5, 12'h00ff, 12'h0456, 3'b000});
      chk("phase", 32'(phase_accum), 32'h0400);
      chk("phen", 32'(phase_adjust_enable), 32'h0);
      chk("fractional_numerator", 32'(fractional_numerator), 32'({12'h0456, 13'h0001}));
      chk("phase pulses", n_phs, 32'h2);
      host.send_word(r1(1'b0, 13'h0002, 12'h000));
      host.send_word({1'b0, 4'h3, 12'h0077, 12'h0456, 3'b000});
      chk("fractional_numerator", 32'(fractional_numerator), 32'({12'h0456, 13'h0002}));
      chk("int", 32'(integer_value), 32'h0077);
      chk("phase", 32'(phase_accum), 32'h0400);
      chk("phase pulses", n_phs, 32'h2);
      $display("test phase adjust done");
      for (int s = 3; s < 8; s++)
      begin
         host.send_word({4'(s), 25'h15a_a5a5, 3'(s)});
         chk("direct", direct_out(s), {4'(s), 25'h15a_a5a5, 3'(s)});
      end
      chk("updates", n_upd, 32'h4);
      $display("test direct registers done");
      print_verdict();
   end
endmodule // sscr_config_top_tb
